// *** design/fer_addr_cap.sv ***
// fault address holder that keeps the first address until cleared
`timescale 1ns/100ps
module fer_addr_cap (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// capture request
	input wire logic i_cap,
	input wire logic [fer_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_clr,
	// held address
	output logic [fer_pkg::ADDR_W-1:0] o_addr,
	output logic o_valid
);
	import fer_pkg::*;

	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic valid_reg;
	logic valid_next;

	// a later fault must not overwrite the address the handler still needs
	always_comb begin
		addr_next = addr_reg;
		valid_next = valid_reg & ~i_clr;
		if (i_cap && (!valid_reg || i_clr)) begin
			addr_next = i_addr;
		end
		if (i_cap) begin
			valid_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			addr_reg <= ADDR_RST;
			valid_reg <= FLAG_RST;
		end else begin
			addr_reg <= addr_next;
			valid_reg <= valid_next;
		end
	end

	assign o_addr = addr_reg;
	assign o_valid = valid_reg;
endmodule

// *** design/fer_fault_escalation_unit.sv ***
// fault classification, status recording and escalation to hard fault
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1 - configurable faults have priority and enable
// RULE2 - entry decided by priority and masks
// RULE3 - same-kind fault in handler escalates
// RULE4 - equal or lower than serviced fault escalates
// RULE5 - equal or lower than executing exception escalates
// RULE6 - fault with disabled handler escalates
// RULE7 - stacking error entering bus handler never escalates
// RULE8 - hard fault preempted only by reset, NMI
// RULE9 - hard fault preempts all but reset, NMI, hard
// RULE10 - record causes; capture mem and bus addresses
// RULE11 - distinct bits for stack, unstack, prefetch, lazy
// RULE12 - exact and inexact data bus errors separate
// RULE13 - lazy save bit only with FPU
// RULE14 - coprocessor and undefined opcode usage bits
// RULE15 - bad state and bad return usage bits
// RULE16 - bad state: non-native set or continuation
// RULE17 - unaligned and zero divisor usage bits
// RULE18 - execute-never fetch faults regardless of MPU
// RULE19 - escalated fault still sets its cause bit
////////////////////////////////////////////////////////////////////////////////
module fer_fault_escalation_unit (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// memory management sources
	input wire logic i_fetch_valid,
	input wire logic i_fetch_exec_never,
	input wire logic i_mpu_enable,
	input wire logic i_mpu_data_viol,
	input wire logic [fer_pkg::ADDR_W-1:0] i_mem_fault_addr,
	// bus error sources
	input wire logic i_berr_stacking,
	input wire logic i_berr_unstacking,
	input wire logic i_berr_prefetch,
	input wire logic i_berr_lazy_fp,
	input wire logic i_berr_data_exact,
	input wire logic i_berr_data_inexact,
	input wire logic [fer_pkg::ADDR_W-1:0] i_bus_fault_addr,
	input wire fer_pkg::fer_exc_t i_stack_exc,
	// usage sources
	input wire logic i_undefined_opcode,
	input wire logic i_coproc_access,
	input wire logic i_isa_switch_valid,
	input wire logic i_isa_switch_native,
	input wire logic i_exception_return_valid,
	input wire logic i_exception_return_code_ok,
	input wire logic i_ret_continuation,
	input wire logic i_ret_target_ldm_stm,
	input wire logic i_unaligned_access,
	input wire logic i_zero_divisor,
	// priority and enable configuration
	input wire logic [fer_pkg::PRIO_W-1:0] i_mem_prio,
	input wire logic [fer_pkg::PRIO_W-1:0] i_bus_prio,
	input wire logic [fer_pkg::PRIO_W-1:0] i_usage_prio,
	input wire logic i_mem_en,
	input wire logic i_bus_en,
	input wire logic i_usage_en,
	// exception masks and current execution
	input wire logic i_primask,
	input wire logic i_faultmask,
	input wire logic [fer_pkg::PRIO_W-1:0] i_basepri,
	input wire fer_pkg::fer_exc_t i_cur_exc,
	input wire logic [fer_pkg::PRIO_W-1:0] i_cur_prio,
	// status clears
	input wire logic [fer_pkg::MEM_W-1:0] i_mem_status_clr,
	input wire logic [fer_pkg::BUS_W-1:0] i_bus_status_clr,
	input wire logic [fer_pkg::USAGE_W-1:0] i_usage_status_clr,
	input wire logic i_mem_addr_clr,
	input wire logic i_bus_addr_clr,
	// exception entry requests
	output logic o_take_valid,
	output fer_pkg::fer_exc_t o_take_exc,
	output logic [fer_pkg::CLS_N-1:0] o_pending_cfg,
	output logic o_pending_hard,
	output logic o_lockup,
	// status and addresses
	output logic [fer_pkg::MEM_W-1:0] o_mem_status,
	output logic [fer_pkg::BUS_W-1:0] o_bus_status,
	output logic [fer_pkg::USAGE_W-1:0] o_usage_status,
	output logic [fer_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_mem_addr_valid,
	output logic [fer_pkg::ADDR_W-1:0] o_bus_addr,
	output logic o_bus_addr_valid
);
	import fer_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// cause decode

	fer_flag_if #(.W(MEM_W)) mem_flags();
	fer_flag_if #(.W(BUS_W)) bus_flags();
	fer_flag_if #(.W(USAGE_W)) usage_flags();

	logic bad_state;
	logic bad_ret;
	logic bus_entry_stack;

	always_comb begin
		// RULE16 non-native set or continuation
		bad_state = (i_isa_switch_valid && !i_isa_switch_native)
			|| (i_exception_return_valid && i_ret_continuation && !i_ret_target_ldm_stm);
		bad_ret = i_exception_return_valid && !i_exception_return_code_ok;
		bus_entry_stack = i_berr_stacking && (i_stack_exc == FER_EXC_BUS);

		mem_flags.set = '0;
		// RULE18 execute-never ignores mpu
		mem_flags.set[MEM_BIT_EXEC_NEVER] = i_fetch_valid && i_fetch_exec_never;
		mem_flags.set[MEM_BIT_DATA] = i_mpu_enable && i_mpu_data_viol;

		bus_flags.set = '0;
		// RULE11 separate timing bits
		bus_flags.set[BUS_BIT_STACK] = i_berr_stacking;
		bus_flags.set[BUS_BIT_UNSTACK] = i_berr_unstacking;
		bus_flags.set[BUS_BIT_PREFETCH] = i_berr_prefetch;
		// RULE13 fpu variant only
		bus_flags.set[BUS_BIT_LAZY_FP] = HAS_FPU && i_berr_lazy_fp;
		// RULE12 exact versus inexact
		bus_flags.set[BUS_BIT_EXACT] = i_berr_data_exact;
		bus_flags.set[BUS_BIT_INEXACT] = i_berr_data_inexact;

		usage_flags.set = '0;
		// RULE14 coprocessor and undefined
		usage_flags.set[USAGE_BIT_COPROC] = i_coproc_access;
		usage_flags.set[USAGE_BIT_UNDEF] = i_undefined_opcode;
		// RULE15 bad state and return
		usage_flags.set[USAGE_BIT_BAD_STATE] = bad_state;
		usage_flags.set[USAGE_BIT_BAD_RET] = bad_ret;
		// RULE17 unaligned and zero divisor
		usage_flags.set[USAGE_BIT_UNALIGN] = i_unaligned_access;
		usage_flags.set[USAGE_BIT_ZDIV] = i_zero_divisor;

		mem_flags.clr = i_mem_status_clr;
		bus_flags.clr = i_bus_status_clr;
		usage_flags.clr = i_usage_status_clr;
	end

	// RULE10 cause bits recorded
	// RULE19 set even when escalated
	fer_sticky #(.W(MEM_W)) u_mem_status (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.flags(mem_flags)
	);

	fer_sticky #(.W(BUS_W)) u_bus_status (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.flags(bus_flags)
	);

	fer_sticky #(.W(USAGE_W)) u_usage_status (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.flags(usage_flags)
	);

	// RULE10 faulting address capture
	fer_addr_cap u_mem_addr (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_cap(mem_flags.set[MEM_BIT_DATA]),
		.i_addr(i_mem_fault_addr),
		.i_clr(i_mem_addr_clr),
		.o_addr(o_mem_addr),
		.o_valid(o_mem_addr_valid)
	);

	fer_addr_cap u_bus_addr (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_cap(i_berr_data_exact),
		.i_addr(i_bus_fault_addr),
		.i_clr(i_bus_addr_clr),
		.o_addr(o_bus_addr),
		.o_valid(o_bus_addr_valid)
	);

	assign o_mem_status = mem_flags.bits;
	assign o_bus_status = bus_flags.bits;
	assign o_usage_status = usage_flags.bits;

	////////////////////////////////////////////////////////////////////////////
	// priorities

	logic [RANK_W-1:0] cfg_rank [CLS_N];
	logic [CLS_N-1:0] cfg_en;
	logic [CLS_N-1:0] raise_sync;
	logic [CLS_N-1:0] raise_async;
	logic [RANK_W-1:0] cur_rank;
	logic [RANK_W-1:0] exec_rank;

	always_comb begin
		// RULE1 per-class priority and enable
		cfg_rank[CLS_MEM] = fer_to_rank(i_mem_prio);
		cfg_rank[CLS_BUS] = fer_to_rank(i_bus_prio);
		cfg_rank[CLS_USAGE] = fer_to_rank(i_usage_prio);
		cfg_en = {i_usage_en, i_bus_en, i_mem_en};

		raise_sync[CLS_MEM] = |mem_flags.set;
		// RULE7 entry stacking error is only recorded
		raise_sync[CLS_BUS] = i_berr_unstacking || i_berr_prefetch || i_berr_data_exact
			|| (HAS_FPU && i_berr_lazy_fp) || (i_berr_stacking && !bus_entry_stack);
		raise_sync[CLS_USAGE] = |usage_flags.set;
		// inexact errors arrive late, so they wait instead of escalating unless the bus handler is disabled
		raise_async = '0;
		raise_async[CLS_BUS] = i_berr_data_inexact;

		case (i_cur_exc)
			FER_EXC_THREAD: cur_rank = RANK_THREAD;
			FER_EXC_RESET: cur_rank = RANK_RESET;
			FER_EXC_NMI: cur_rank = RANK_NMI;
			FER_EXC_HARD: cur_rank = RANK_HARD;
			FER_EXC_MEM: cur_rank = cfg_rank[CLS_MEM];
			FER_EXC_BUS: cur_rank = cfg_rank[CLS_BUS];
			FER_EXC_USAGE: cur_rank = cfg_rank[CLS_USAGE];
			FER_EXC_OTHER: cur_rank = fer_to_rank(i_cur_prio);
			default: cur_rank = RANK_THREAD;
		endcase

		// RULE2 masks raise the execution priority
		exec_rank = cur_rank;
		if (i_basepri != 8'h00 && fer_to_rank(i_basepri) < exec_rank) begin
			exec_rank = fer_to_rank(i_basepri);
		end
		if (i_primask && RANK_CFG_BASE < exec_rank) begin
			exec_rank = RANK_CFG_BASE;
		end
		if (i_faultmask && RANK_HARD < exec_rank) begin
			exec_rank = RANK_HARD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// escalation and entry arbitration

	logic [CLS_N-1:0] pend_cfg_reg;
	logic [CLS_N-1:0] pend_cfg_next;
	logic pend_hard_reg;
	logic pend_hard_next;
	logic lockup_reg;
	logic lockup_next;
	logic take_valid_reg;
	logic take_valid_next;
	fer_exc_t take_exc_reg;
	fer_exc_t take_exc_next;

	always_comb begin
		logic escalate;
		logic room;
		logic [RANK_W-1:0] best;
		logic [CLS_N-1:0] pend_set;
		logic [CLS_N-1:0] take_mask;
		escalate = 1'b0;
		room = 1'b0;
		best = exec_rank;
		pend_set = '0;
		take_mask = '0;
		take_valid_next = 1'b0;
		take_exc_next = take_exc_reg;

		for (int c = 0; c < CLS_N; c++) begin
			// RULE4 not above the serviced fault
			// RULE5 not above the executing exception
			room = cfg_en[c] && (cfg_rank[c] < exec_rank);
			// RULE3 a handler cannot preempt itself
			if (i_cur_exc == fer_cls_exc(c)) begin
				room = 1'b0;
			end
			if (raise_sync[c]) begin
				if (room) begin
					pend_set[c] = 1'b1;
				end else begin
					escalate = 1'b1;
				end
			end
			if (raise_async[c]) begin
				// RULE6 disabled handler escalates
				if (!cfg_en[c]) begin
					escalate = 1'b1;
				end else begin
					pend_set[c] = 1'b1;
				end
			end
		end

		// best configurable candidate, lower class index wins a tie
		for (int c = 0; c < CLS_N; c++) begin
			if (pend_cfg_reg[c] && cfg_en[c] && cfg_rank[c] < best) begin
				best = cfg_rank[c];
				take_mask = '0;
				take_mask[c] = 1'b1;
				take_valid_next = 1'b1;
				take_exc_next = fer_cls_exc(c);
			end
		end

		// RULE9 hard fault preempts below its rank
		// RULE8 only reset, nmi, hard fault itself and faultmask hold it off
		pend_hard_next = pend_hard_reg;
		if (pend_hard_reg && RANK_HARD < exec_rank) begin
			take_mask = '0;
			take_valid_next = 1'b1;
			take_exc_next = FER_EXC_HARD;
			pend_hard_next = 1'b0;
		end

		// a fault escalated inside hard fault or nmi has nowhere to go
		lockup_next = lockup_reg;
		if (escalate) begin
			if (cur_rank <= RANK_HARD) begin
				lockup_next = 1'b1;
			end else begin
				pend_hard_next = 1'b1;
			end
		end

		pend_cfg_next = (pend_cfg_reg & ~take_mask) | pend_set;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pend_cfg_reg <= '0;
			pend_hard_reg <= FLAG_RST;
			lockup_reg <= FLAG_RST;
			take_valid_reg <= FLAG_RST;
			take_exc_reg <= FER_EXC_THREAD;
		end else begin
			pend_cfg_reg <= pend_cfg_next;
			pend_hard_reg <= pend_hard_next;
			lockup_reg <= lockup_next;
			take_valid_reg <= take_valid_next;
			take_exc_reg <= take_exc_next;
		end
	end

	assign o_take_valid = take_valid_reg;
	assign o_take_exc = take_exc_reg;
	assign o_pending_cfg = pend_cfg_reg;
	assign o_pending_hard = pend_hard_reg;
	assign o_lockup = lockup_reg;
endmodule

// *** design/fer_flag_if.sv ***
// set, clear and stored bits of one sticky status group
`timescale 1ns/100ps
interface fer_flag_if #(parameter int W = 1);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] bits;
	modport store (input set, input clr, output bits);
	modport ctrl (output set, output clr, input bits);
endinterface

// *** design/fer_pkg.sv ***
// constants, encodings and helpers shared by the fault escalation unit
package fer_pkg;

	// widths
	localparam int PRIO_W = 8;
	localparam int RANK_W = 9;
	localparam int ADDR_W = 32;

	// fault classes with a configurable priority
	localparam int CLS_N = 3;
	localparam int CLS_MEM = 0;
	localparam int CLS_BUS = 1;
	localparam int CLS_USAGE = 2;

	// ranks: a lower rank is a higher priority
	localparam logic [RANK_W-1:0] RANK_RESET = 9'h000;
	localparam logic [RANK_W-1:0] RANK_NMI = 9'h001;
	localparam logic [RANK_W-1:0] RANK_HARD = 9'h002;
	localparam logic [RANK_W-1:0] RANK_CFG_BASE = 9'h003;
	localparam logic [RANK_W-1:0] RANK_THREAD = 9'h1ff;

	// memory management status bits
	localparam int MEM_W = 2;
	localparam int MEM_BIT_EXEC_NEVER = 0;
	localparam int MEM_BIT_DATA = 1;

	// bus fault status bits
	localparam int BUS_W = 6;
	localparam int BUS_BIT_PREFETCH = 0;
	localparam int BUS_BIT_EXACT = 1;
	localparam int BUS_BIT_INEXACT = 2;
	localparam int BUS_BIT_UNSTACK = 3;
	localparam int BUS_BIT_STACK = 4;
	localparam int BUS_BIT_LAZY_FP = 5;

	// usage fault status bits
	localparam int USAGE_W = 6;
	localparam int USAGE_BIT_UNDEF = 0;
	localparam int USAGE_BIT_BAD_STATE = 1;
	localparam int USAGE_BIT_BAD_RET = 2;
	localparam int USAGE_BIT_COPROC = 3;
	localparam int USAGE_BIT_UNALIGN = 4;
	localparam int USAGE_BIT_ZDIV = 5;

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
	localparam logic FLAG_RST = 1'b0;

	// core variant with the floating-point unit
	localparam logic HAS_FPU = 1'b1;

	typedef enum logic [2:0] {
		FER_EXC_THREAD = 3'b000,
		FER_EXC_RESET = 3'b001,
		FER_EXC_NMI = 3'b010,
		FER_EXC_HARD = 3'b011,
		FER_EXC_MEM = 3'b100,
		FER_EXC_BUS = 3'b101,
		FER_EXC_USAGE = 3'b110,
		FER_EXC_OTHER = 3'b111
	} fer_exc_t;

	function automatic logic [RANK_W-1:0] fer_to_rank(input logic [PRIO_W-1:0] prio);
		fer_to_rank = RANK_W'({1'b0, prio}) + RANK_CFG_BASE;
	endfunction

	function automatic fer_exc_t fer_cls_exc(input int cls);
		if (cls == CLS_MEM) begin
			fer_cls_exc = FER_EXC_MEM;
		end else if (cls == CLS_BUS) begin
			fer_cls_exc = FER_EXC_BUS;
		end else begin
			fer_cls_exc = FER_EXC_USAGE;
		end
	endfunction

endpackage

// *** design/fer_sticky.sv ***
// sticky status bits where a set in the clearing cycle wins
`timescale 1ns/100ps
module fer_sticky #(parameter int W = 1) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// status group
	fer_flag_if.store flags
);
	import fer_pkg::*;

	logic [W-1:0] bits_reg;
	logic [W-1:0] bits_next;

	// a clear never swallows an event of the same cycle
	always_comb begin
		bits_next = (bits_reg & ~flags.clr) | flags.set;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			bits_reg <= {W{FLAG_RST}};
		end else begin
			bits_reg <= bits_next;
		end
	end

	assign flags.bits = bits_reg;
endmodule

// *** verif/fer_esc_checker.sv ***
// concurrent checks on the fault escalation unit ports
`timescale 1ns/100ps
module fer_esc_checker (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// fault sources and context
	input wire logic i_zero_divisor,
	input wire logic i_usage_en,
	input wire logic i_fetch_valid,
	input wire logic i_fetch_exec_never,
	input wire logic i_berr_prefetch,
	input wire logic i_berr_stacking,
	input wire logic i_berr_data_exact,
	input wire logic [fer_pkg::ADDR_W-1:0] i_bus_fault_addr,
	input wire fer_pkg::fer_exc_t i_stack_exc,
	input wire fer_pkg::fer_exc_t i_cur_exc,
	input wire logic i_faultmask,
	// watched outputs
	input wire logic o_take_valid,
	input wire fer_pkg::fer_exc_t o_take_exc,
	input wire logic o_pending_hard,
	input wire logic o_lockup,
	input wire logic [fer_pkg::MEM_W-1:0] o_mem_status,
	input wire logic [fer_pkg::BUS_W-1:0] o_bus_status,
	input wire logic [fer_pkg::USAGE_W-1:0] o_usage_status,
	input wire logic [fer_pkg::ADDR_W-1:0] o_bus_addr,
	input wire logic o_bus_addr_valid
);
	import fer_pkg::*;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////////
	a_zdiv_bit: assert property (i_zero_divisor |=> o_usage_status[USAGE_BIT_ZDIV])
		else $error("zero divisor bit missing");
	a_exec_never_bit: assert property (i_fetch_valid && i_fetch_exec_never |=>
		o_mem_status[MEM_BIT_EXEC_NEVER]) else $error("execute-never bit missing");
	a_prefetch_bit: assert property (i_berr_prefetch |=> o_bus_status[BUS_BIT_PREFETCH])
		else $error("prefetch bit missing");
	a_exact_addr: assert property (i_berr_data_exact && !o_bus_addr_valid |=>
		o_bus_addr_valid && o_bus_addr == $past(i_bus_fault_addr)) else $error("bus address not captured");
	a_off_escalates: assert property (i_zero_divisor && !i_usage_en && i_cur_exc == FER_EXC_THREAD |=>
		o_pending_hard) else $error("disabled fault not escalated");
	a_same_kind: assert property (i_zero_divisor && i_cur_exc == FER_EXC_USAGE |=> o_pending_hard)
		else $error("same kind fault not escalated");
	a_hard_taken: assert property ($rose(o_pending_hard) && i_cur_exc == FER_EXC_THREAD && !i_faultmask |=>
		o_take_valid && o_take_exc == FER_EXC_HARD) else $error("hard fault not taken");
	a_stack_in_bus: assert property (i_berr_stacking && i_stack_exc == FER_EXC_BUS |=>
		o_bus_status[BUS_BIT_STACK] && !$rose(o_pending_hard)) else $error("stacking error escalated");
	a_hard_lockup: assert property (i_zero_divisor && i_cur_exc == FER_EXC_HARD |=>
		(o_lockup && !o_pending_hard) [*2]) else $error("fault inside hard handler not locked");
	c_take_usage: cover property (o_take_valid && o_take_exc == FER_EXC_USAGE);
	c_take_hard: cover property (o_take_valid && o_take_exc == FER_EXC_HARD);
	c_lockup: cover property ($rose(o_lockup));
endmodule
bind fer_fault_escalation_unit fer_esc_checker fer_esc_checker_inst (.i_clk_sys, .i_rst, .i_zero_divisor,
	.i_usage_en, .i_fetch_valid, .i_fetch_exec_never, .i_berr_prefetch, .i_berr_stacking, .i_berr_data_exact,
	.i_bus_fault_addr, .i_stack_exc, .i_cur_exc, .i_faultmask, .o_take_valid, .o_take_exc, .o_pending_hard,
	.o_lockup, .o_mem_status, .o_bus_status, .o_usage_status, .o_bus_addr, .o_bus_addr_valid);

// *** verif/fer_fault_escalation_unit_bench.sv ***
// self-checking bench for the fault escalation unit
`timescale 1ns/100ps
module fer_fault_escalation_unit_bench;
	import fer_pkg::*;
	localparam logic [13:0] EXP [17] = '{14'h2000, 14'h0100, 14'h0800, 14'h1000, 14'h0001, 14'h0002, 14'h0040,
		14'h0020, 14'h0004, 14'h0080, 14'h0008, 14'h0010, 14'h0200, 14'h0000, 14'h0400, 14'h0200, 14'h0000};
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic go = 1'b0;
	logic [4:0] code = 5'h00;
	logic [19:0] src;
	logic [2:0] en = 3'h7;
	logic [2:0] msk = 3'h0;
	logic [7:0] prio [3] = '{8'h10, 8'h20, 8'h30};
	logic [7:0] bp = 8'h00;
	fer_exc_t cur = FER_EXC_THREAD;
	fer_exc_t stk = FER_EXC_THREAD;
	logic [13:0] clr = 14'h0000;
	logic aclr = 1'b0;
	logic [31:0] addr = 32'h0000_0000;
	logic [31:0] seed = 32'h62af;
	logic tv, ph, lk, mav, bav;
	fer_exc_t te;
	logic [2:0] pc;
	logic [1:0] ms;
	logic [5:0] bs, us;
	logic [31:0] ma, ba;
	fer_exc_t q [$];
	int mismatches = 0;
	int n_compared = 0;
	always #2 i_clk_sys = ~i_clk_sys;
	fer_pipe_model fer_pipe_model_inst (.i_clk_sys, .i_go(go), .i_code(code), .o_src(src));
	fer_fault_escalation_unit fer_fault_escalation_unit_inst (.i_clk_sys, .i_rst, .i_fetch_valid(src[4]),
		.i_fetch_exec_never(src[5]), .i_mpu_enable(src[6]), .i_mpu_data_viol(src[7]), .i_mem_fault_addr(addr),
		.i_berr_stacking(src[8]), .i_berr_unstacking(src[9]), .i_berr_prefetch(src[10]), .i_berr_lazy_fp(src[11]),
		.i_berr_data_exact(src[12]), .i_berr_data_inexact(src[13]), .i_bus_fault_addr(addr), .i_stack_exc(stk),
		.i_undefined_opcode(src[1]), .i_coproc_access(src[2]), .i_isa_switch_valid(src[14]),
		.i_isa_switch_native(src[15]), .i_exception_return_valid(src[16]), .i_exception_return_code_ok(src[17]),
		.i_ret_continuation(src[18]), .i_ret_target_ldm_stm(src[19]), .i_unaligned_access(src[3]),
		.i_zero_divisor(src[0]), .i_mem_prio(prio[0]), .i_bus_prio(prio[1]), .i_usage_prio(prio[2]),
		.i_mem_en(en[0]), .i_bus_en(en[1]), .i_usage_en(en[2]), .i_primask(msk[2]), .i_faultmask(msk[1]),
		.i_basepri(bp), .i_cur_exc(cur), .i_cur_prio(prio[1]), .i_mem_status_clr(clr[1:0]),
		.i_bus_status_clr(clr[7:2]), .i_usage_status_clr(clr[13:8]), .i_mem_addr_clr(aclr), .i_bus_addr_clr(aclr),
		.o_take_valid(tv), .o_take_exc(te), .o_pending_cfg(pc), .o_pending_hard(ph), .o_lockup(lk),
		.o_mem_status(ms), .o_bus_status(bs), .o_usage_status(us), .o_mem_addr(ma), .o_mem_addr_valid(mav),
		.o_bus_addr(ba), .o_bus_addr_valid(bav));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic fer_exc_t cls(input logic [13:0] e);
		if (e[1:0] != 0) return FER_EXC_MEM;
		if (e[7:2] != 0) return FER_EXC_BUS;
		return FER_EXC_USAGE;
	endfunction
	// takes may lag, so the wait is bounded on the queue draining
	task automatic settle();
		repeat (4) @(negedge i_clk_sys);
		for (int n = 0; n < 20 && q.size() != 0; n++) @(negedge i_clk_sys);
		if (q.size() != 0) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	task automatic pulse(input int k);
		code <= 5'(k);
		go <= 1'b1;
		@(negedge i_clk_sys);
		go <= 1'b0;
	endtask
	task automatic fire(input int k, input fer_exc_t e, input logic want);
		if (want) q.push_back(e);
		pulse(k);
		settle();
	endtask
	task automatic wipe();
		clr = 14'h3fff;
		aclr = 1'b1;
		@(negedge i_clk_sys);
		clr = 14'h0000;
		aclr = 1'b0;
	endtask
	task automatic reset();
		i_rst = 1'b1;
		repeat (6) @(negedge i_clk_sys);
		i_rst = 1'b0;
		@(negedge i_clk_sys);
		check({tv, ph, lk, pc, ms, bs, us}, 0, "idle");
	endtask
	// masks are dropped after the fault so a held-off hard fault can still arrive
	task automatic esc(input fer_exc_t c, input int off, input logic [2:0] m, input fer_exc_t e);
		cur = c;
		prio[1] = 8'(prio[2] + off);
		msk = m;
		bp = m[0] ? prio[2] : 8'h00;
		q.push_back(e);
		pulse(0);
		repeat (4) @(negedge i_clk_sys);
		msk = 3'h0;
		bp = 8'h00;
		cur = FER_EXC_THREAD;
		settle();
	endtask
	always @(negedge i_clk_sys) begin
		if (tv === 1'b1) begin
			if (q.size() == 0) begin
				check(0, 1, "spare take");
			end else begin
				check(te, q.pop_front(), "take");
			end
		end
	end
	initial begin
		reset();
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 17; k++) begin
				prio = '{8'(rnd() % 250), 8'(rnd() % 250), 8'(rnd() % 250)};
				addr = rnd();
				en = p ? 3'h0 : 3'h7;
				fire(k, p ? FER_EXC_HARD : cls(EXP[k]), EXP[k] != 0);
				check({us, bs, ms}, EXP[k], "status");
				if (k == 5) check({mav, ma}, {1'b1, addr}, "mem addr");
				if (k == 10) check({bav, ba}, {1'b1, addr}, "bus addr");
				wipe();
			end
		end
		stk = FER_EXC_BUS;
		fire(6, FER_EXC_BUS, 1'b0);
		check({ph, bs}, 7'h10, "stack in bus");
		stk = FER_EXC_THREAD;
		// the disabled pass left every handler off; the priority cases need them on
		en = 3'h7;
		wipe();
		prio[2] = 8'(1 + rnd() % 200);
		esc(FER_EXC_USAGE, 0, 3'b000, FER_EXC_HARD);
		esc(FER_EXC_BUS, 0, 3'b000, FER_EXC_HARD);
		esc(FER_EXC_BUS, 1, 3'b000, FER_EXC_USAGE);
		esc(FER_EXC_OTHER, 0, 3'b000, FER_EXC_HARD);
		esc(FER_EXC_OTHER, 1, 3'b000, FER_EXC_USAGE);
		esc(FER_EXC_THREAD, 0, 3'b100, FER_EXC_HARD);
		esc(FER_EXC_THREAD, 0, 3'b010, FER_EXC_HARD);
		esc(FER_EXC_THREAD, 0, 3'b001, FER_EXC_HARD);
		cur = FER_EXC_HARD;
		fire(0, FER_EXC_HARD, 1'b0);
		check({lk, ph}, 2'b10, "lockup");
		cur = FER_EXC_THREAD;
		reset();
		tally_and_finish();
	end
endmodule

// *** verif/fer_pipe_model.sv ***
// pipeline side model that raises fault source lines for one cycle
`timescale 1ns/100ps
module fer_pipe_model (
	// clock
	input wire logic i_clk_sys,
	// fault request
	input wire logic i_go,
	input wire logic [4:0] i_code,
	// source lines toward the unit
	output logic [19:0] o_src
);
	// one source pattern per fault code, state and return cases last
	// codes 13 and 16 are a legal switch and a legal return that must leave status alone
	localparam logic [19:0] TBL [17] = '{20'h00001, 20'h00002, 20'h00004, 20'h00008, 20'h00030, 20'h000c0,
		20'h00100, 20'h00200, 20'h00400, 20'h00800, 20'h01000, 20'h02000, 20'h04000, 20'h0c000, 20'h10000,
		20'h70000, 20'hf0000};
	initial o_src = 20'h00000;
	// a held line would count again every cycle, so only one cycle is driven
	always @(negedge i_clk_sys) begin
		o_src <= i_go ? TBL[i_code] : 20'h00000;
	end
endmodule
